// File: hdl/oadc_serial_ctrl.sv
// octal 12-bit converter serial output and power control, with an AXI4-Lite register port
`timescale 1ns/10ps
`include "oadc_regs.svh"
module oadc_serial_ctrl #(
	parameter int PD_RECOVERY_CYC = `OADC_PD_CYC,
	parameter int PARTIAL_CYC     = `OADC_PARTIAL_CYC,
	parameter int RELOCK_CYC      = `OADC_RELOCK_CYC,
	parameter int MIN_FREQ_KHZ    = `OADC_MIN_FREQ_KHZ
) (
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	input  wire logic [3:0]            axi_awaddr_in,
	input  wire logic                  axi_awvalid_in,
	output logic                       axi_awready_out,
	input  wire logic [31:0]           axi_wdata_in,
	input  wire logic [3:0]            axi_wstrb_in,
	input  wire logic                  axi_wvalid_in,
	output logic                       axi_wready_out,
	output logic [1:0]                 axi_bresp_out,
	output logic                       axi_bvalid_out,
	input  wire logic                  axi_bready_in,
	input  wire logic [3:0]            axi_araddr_in,
	input  wire logic                  axi_arvalid_in,
	output logic                       axi_arready_out,
	output logic [31:0]                axi_rdata_out,
	output logic [1:0]                 axi_rresp_out,
	output logic                       axi_rvalid_out,
	input  wire logic                  axi_rready_in,
	input  wire oadc_pkg::oadc_words_t adc_data_in,
	input  wire logic                  sample_clock_in,
	input  wire logic                  power_down_pin_in,
	output oadc_pkg::oadc_lanes_t      data_lane_out,
	output oadc_pkg::oadc_pair_t       bit_clock_pair_out,
	output oadc_pkg::oadc_pair_t       frame_clock_pair_out,
	output logic [1:0]                 drive_sel_out,
	output logic [`OADC_CHANS-1:0]     chan_enable_out,
	output logic                       ref_enable_out,
	output logic                       clock_circuit_enable_out,
	output logic                       partial_pd_out,
	output logic                       data_valid_out
);
	import oadc_pkg::*;

	localparam int SLOW_CYC = (1000000 / MIN_FREQ_KHZ) / `OADC_CLK_PERIOD_NS;

	oadc_top_st_t               s_q;
	oadc_top_st_t               s_d;
	logic                       clk_stopped;
	logic                       clk_slow;
	logic                       clk_brief;
	logic                       clk_bad;
	logic                       load_w;
	logic                       order_msb;
	logic                       drivers_on;
	logic [`OADC_CHANS-1:0]     lane_bit;
	oadc_words_t                lane_word;

	if (PD_RECOVERY_CYC < 1 || PD_RECOVERY_CYC > 65535 || PARTIAL_CYC < 1 || PARTIAL_CYC > 65535 ||
	    RELOCK_CYC < 1 || RELOCK_CYC > 65535 || MIN_FREQ_KHZ < 1 || SLOW_CYC < 1 || SLOW_CYC > 254) begin : g_chk
		$error("oadc_serial_ctrl: recovery counts or minimum frequency out of range");
	end

	// byte-lane merge of a write into a register word
	function automatic logic [31:0] merge_w(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_w

	oadc_clk_mon #(
		.STOP_CYC (`OADC_STOP_CYC),
		.SLOW_CYC (SLOW_CYC)
	) u_mon (
		.clk_in          (clk_in),
		.reset_in        (reset_in),
		.sample_clock_in (sample_clock_in),
		.stopped_out     (clk_stopped),
		.slow_out        (clk_slow),
		.brief_out       (clk_brief)
	);

	assign clk_bad = clk_stopped | clk_slow;

	// the last bit of a frame loads every lane so its first bit lines up with the frame clock
	assign load_w = (s_q.bit_cnt == 4'(`OADC_BITS - 1));

	// deskew and sync patterns are defined in time order, so they always leave MSB first; the custom pattern follows the MSB bit
	assign order_msb = s_q.ctrl[`OADC_CTRL_MSB] | s_q.ctrl[`OADC_CTRL_DESKEW] | s_q.ctrl[`OADC_CTRL_SYNC];

	// per-lane word choice: reset zero, then deskew, sync, custom, then data or a dead channel
	generate
		for (genvar ch = 0; ch < `OADC_CHANS; ch++) begin : g_lane
			always_comb begin
				if (reset_in) begin
					lane_word[ch] = `OADC_ZERO_WORD;
				end else if (s_q.ctrl[`OADC_CTRL_DESKEW]) begin
					lane_word[ch] = `OADC_DESKEW_WORD;
				end else if (s_q.ctrl[`OADC_CTRL_SYNC]) begin
					lane_word[ch] = `OADC_SYNC_WORD;
				end else if (s_q.ctrl[`OADC_CTRL_CUSTOM]) begin
					lane_word[ch] = s_q.patt[`OADC_BITS-1:0];
				end else if (s_q.chpd[ch]) begin
					lane_word[ch] = `OADC_ZERO_WORD;
				end else begin
					lane_word[ch] = adc_data_in[ch];
				end
			end

			oadc_lane_ser #(
				.BITS (`OADC_BITS)
			) u_ser (
				.clk_in       (clk_in),
				.reset_in     (reset_in),
				.load_in      (load_w),
				.msb_first_in (order_msb),
				.word_in      (lane_word[ch]),
				.bit_out      (lane_bit[ch])
			);

			assign data_lane_out[ch].p  = lane_bit[ch];
			assign data_lane_out[ch].n  = ~lane_bit[ch];
			assign data_lane_out[ch].oe = drivers_on;
			assign chan_enable_out[ch]  = drivers_on & ~s_q.chpd[ch];
		end
	endgenerate

	// register port, power sequencing and frame timing in one next-state process
	always_comb begin
		s_d = s_q;

		// write address and data are taken independently, answered once both are held
		if (axi_awvalid_in && axi_awready_out) begin
			s_d.aw_got = 1'b1;
			s_d.waddr  = axi_awaddr_in;
		end
		if (axi_wvalid_in && axi_wready_out) begin
			s_d.w_got = 1'b1;
			s_d.wdata = axi_wdata_in;
			s_d.wstrb = axi_wstrb_in;
		end
		if (s_q.bvalid && axi_bready_in) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `OADC_RESP_OKAY;
			case (s_q.waddr)
				`OADC_ADDR_CTRL: s_d.ctrl = merge_w(s_q.ctrl, s_q.wdata, s_q.wstrb);
				`OADC_ADDR_CHPD: s_d.chpd = merge_w(s_q.chpd, s_q.wdata, s_q.wstrb);
				`OADC_ADDR_PATT: s_d.patt = merge_w(s_q.patt, s_q.wdata, s_q.wstrb);
				default:         s_d.bresp = `OADC_RESP_SLVERR; // status is read-only, others unmapped
			endcase
			// unused high bits stay zero whatever software writes
			s_d.ctrl[31:`OADC_CTRL_DRV_HI+1] = '0;
			s_d.chpd[31:`OADC_CHANS]         = '0;
			s_d.patt[31:`OADC_BITS]          = '0;
		end

		// reads answer one cycle after the address is taken
		if (s_q.rvalid && axi_rready_in) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_arvalid_in && axi_arready_out) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = `OADC_RESP_OKAY;
			s_d.rdata  = '0;
			case (axi_araddr_in)
				`OADC_ADDR_CTRL: s_d.rdata = s_q.ctrl;
				`OADC_ADDR_CHPD: s_d.rdata = s_q.chpd;
				`OADC_ADDR_PATT: s_d.rdata = s_q.patt;
				`OADC_ADDR_STAT: begin
					s_d.rdata[`OADC_ST_FULL_PD] = (s_q.mode == PM_FULL_PD);
					s_d.rdata[`OADC_ST_PARTIAL] = (s_q.mode == PM_PARTIAL);
					s_d.rdata[`OADC_ST_RELOCK]  = (s_q.mode == PM_RELOCK);
					s_d.rdata[`OADC_ST_VALID]   = (s_q.mode == PM_RUN);
				end
				default:         s_d.rresp = `OADC_RESP_SLVERR;
			endcase
		end

		// power-down pin crosses in through two flops before the sequencer reads it
		s_d.pd_sync = {s_q.pd_sync[0], power_down_pin_in};
		if (s_q.timer != '0) begin
			s_d.timer = s_q.timer - 16'h0001;
		end
		case (s_q.mode)
			PM_FULL_PD: begin
				if (!s_q.pd_sync[1]) begin
					s_d.mode  = PM_PD_RECOVER;
					s_d.timer = 16'(PD_RECOVERY_CYC);
				end
			end
			PM_PARTIAL: begin
				if (!clk_bad) begin
					s_d.mode  = PM_PART_RECOVER;
					s_d.timer = 16'(PARTIAL_CYC);
				end
			end
			PM_RUN: begin
				if (clk_bad) begin
					s_d.mode = PM_PARTIAL;
				end else if (clk_brief) begin
					s_d.mode  = PM_RELOCK;
					s_d.timer = 16'(RELOCK_CYC);
				end
			end
			PM_PD_RECOVER, PM_PART_RECOVER, PM_RELOCK: begin
				if (clk_bad) begin
					s_d.mode = PM_PARTIAL;
				end else if (clk_brief && s_q.timer < 16'(RELOCK_CYC)) begin // never shortens a longer wait
					s_d.mode  = PM_RELOCK;
					s_d.timer = 16'(RELOCK_CYC);
				end else if (s_q.timer == '0) begin
					s_d.mode = PM_RUN;
				end
			end
			default: begin
				s_d.mode = PM_FULL_PD;
			end
		endcase
		// the pin wins over every other state
		if (s_q.pd_sync[1]) begin
			s_d.mode = PM_FULL_PD;
		end

		// twelve shift clocks per frame; bit clock toggles each bit, frame clock high for the first half
		s_d.bit_cnt   = load_w ? 4'h0 : s_q.bit_cnt + 4'h1;
		s_d.bit_clk   = ~s_d.bit_cnt[0];
		s_d.frame_clk = s_d.bit_cnt < 4'(`OADC_HALF_BITS);

		// reset clears settings and power state but lets the output clocks run on
		if (reset_in) begin
			s_d.aw_got   = 1'b0;
			s_d.w_got    = 1'b0;
			s_d.waddr    = '0;
			s_d.wdata    = '0;
			s_d.wstrb    = '0;
			s_d.bvalid   = 1'b0;
			s_d.bresp    = `OADC_RESP_OKAY;
			s_d.rvalid   = 1'b0;
			s_d.rdata    = '0;
			s_d.rresp    = `OADC_RESP_OKAY;
			s_d.ctrl     = `OADC_CFG_RESET;
			s_d.chpd     = `OADC_CFG_RESET;
			s_d.patt     = `OADC_CFG_RESET;
			s_d.pd_sync  = '0;
			// drivers stay on through reset so the zero code and both clocks reach the receiver
			s_d.mode     = PM_PD_RECOVER;
			s_d.timer    = 16'(PD_RECOVERY_CYC);
			// zeroed until the flag reads a known one, so an unknown power-up count cannot persist
			if (s_q.rst_seen == 1'b1) begin
				s_d.rst_seen = 1'b1; // clocks keep toggling through later reset cycles
			end else begin
				s_d.rst_seen  = 1'b1;
				s_d.bit_cnt   = 4'h0;
				s_d.bit_clk   = 1'b1;
				s_d.frame_clk = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	// drivers release in full power-down only; partial power-down keeps the link shape
	assign drivers_on = (s_q.mode != PM_FULL_PD);

	assign axi_awready_out = !s_q.aw_got && !s_q.bvalid;
	assign axi_wready_out  = !s_q.w_got && !s_q.bvalid;
	assign axi_bvalid_out  = s_q.bvalid;
	assign axi_bresp_out   = s_q.bresp;
	assign axi_arready_out = !s_q.rvalid;
	assign axi_rvalid_out  = s_q.rvalid;
	assign axi_rdata_out   = s_q.rdata;
	assign axi_rresp_out   = s_q.rresp;

	assign bit_clock_pair_out.p    = s_q.bit_clk;
	assign bit_clock_pair_out.n    = ~s_q.bit_clk;
	assign bit_clock_pair_out.oe   = drivers_on;
	assign frame_clock_pair_out.p  = s_q.frame_clk;
	assign frame_clock_pair_out.n  = ~s_q.frame_clk;
	assign frame_clock_pair_out.oe = drivers_on;

	assign drive_sel_out            = s_q.ctrl[`OADC_CTRL_DRV_HI:`OADC_CTRL_DRV_LO];
	assign ref_enable_out           = drivers_on;
	assign clock_circuit_enable_out = drivers_on;
	assign partial_pd_out           = (s_q.mode == PM_PARTIAL);
	assign data_valid_out           = (s_q.mode == PM_RUN);
endmodule : oadc_serial_ctrl

// File: hdl/oadc_regs.svh
// constants of the octal converter serial output block: offsets, fields, times
`ifndef OADC_REGS_SVH
`define OADC_REGS_SVH

`define OADC_CHANS          8
`define OADC_BITS           12
`define OADC_HALF_BITS      6
`define OADC_CLK_PERIOD_NS  50
`define OADC_STOP_NS        300
`define OADC_MIN_FREQ_KHZ   3000
`define OADC_RELOCK_US      10
`define OADC_PARTIAL_US     100
`define OADC_PD_US          500
`define OADC_STOP_CYC       (`OADC_STOP_NS / `OADC_CLK_PERIOD_NS)
`define OADC_RELOCK_CYC     ((`OADC_RELOCK_US * 1000 + `OADC_CLK_PERIOD_NS - 1) / `OADC_CLK_PERIOD_NS)
`define OADC_PARTIAL_CYC    ((`OADC_PARTIAL_US * 1000 + `OADC_CLK_PERIOD_NS - 1) / `OADC_CLK_PERIOD_NS)
`define OADC_PD_CYC         ((`OADC_PD_US * 1000 + `OADC_CLK_PERIOD_NS - 1) / `OADC_CLK_PERIOD_NS)
`define OADC_CNT_MAX        8'hFF

`define OADC_ADDR_CTRL      4'h0
`define OADC_ADDR_CHPD      4'h4
`define OADC_ADDR_PATT      4'h8
`define OADC_ADDR_STAT      4'hC

`define OADC_CTRL_MSB       0
`define OADC_CTRL_DESKEW    1
`define OADC_CTRL_SYNC      2
`define OADC_CTRL_CUSTOM    3
`define OADC_CTRL_DRV_LO    4
`define OADC_CTRL_DRV_HI    5
`define OADC_ST_FULL_PD     0
`define OADC_ST_PARTIAL     1
`define OADC_ST_RELOCK      2
`define OADC_ST_VALID       3

`define OADC_CFG_RESET      32'h0000_0000
`define OADC_DESKEW_WORD    12'h555
`define OADC_SYNC_WORD      12'h03F
`define OADC_ZERO_WORD      12'h000
`define OADC_RESP_OKAY      2'h0
`define OADC_RESP_SLVERR    2'h2

`endif

// File: hdl/oadc_pkg.sv
// types shared by the octal converter serial output block
`include "oadc_regs.svh"
package oadc_pkg;
	typedef logic [`OADC_BITS-1:0]          oadc_word_t;
	typedef oadc_word_t [`OADC_CHANS-1:0]   oadc_words_t;

	// one differential output: true leg, complement leg, driver enable
	typedef struct packed {
		logic p;
		logic n;
		logic oe;
	} oadc_pair_t;
	typedef oadc_pair_t [`OADC_CHANS-1:0]   oadc_lanes_t;

	typedef enum logic [2:0] {
		PM_RUN,
		PM_FULL_PD,
		PM_PD_RECOVER,
		PM_PARTIAL,
		PM_PART_RECOVER,
		PM_RELOCK
	} oadc_pmode_t;

	typedef struct packed {
		oadc_word_t sh;
		logic       bit_q;
	} oadc_ser_st_t;

	typedef struct packed {
		logic [1:0] sync;
		logic       prev;
		logic [7:0] gap;
		logic [7:0] period;
		logic [7:0] last_period;
		logic       stopped;
		logic       slow;
		logic       brief;
	} oadc_mon_st_t;

	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [3:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] ctrl;
		logic [31:0] chpd;
		logic [31:0] patt;
		logic [1:0]  pd_sync;
		oadc_pmode_t mode;
		logic [15:0] timer;
		logic        rst_seen;
		logic [3:0]  bit_cnt;
		logic        bit_clk;
		logic        frame_clk;
	} oadc_top_st_t;
endpackage : oadc_pkg

// File: hdl/oadc_lane_ser.sv
// one data lane serializer: loads a 12-bit word and shifts it out a bit per clock
`timescale 1ns/10ps
`include "oadc_regs.svh"
module oadc_lane_ser #(
	parameter int BITS = `OADC_BITS
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             load_in,
	input  wire logic             msb_first_in,
	input  wire oadc_pkg::oadc_word_t word_in,
	output logic                  bit_out
);
	import oadc_pkg::*;

	oadc_ser_st_t s_q;
	oadc_ser_st_t s_d;

	if (BITS != `OADC_BITS) begin : g_chk
		$error("oadc_lane_ser: BITS must match the word width");
	end

	// load puts the first bit out at once; order picks which end leaves first
	always_comb begin
		s_d = s_q;
		if (load_in) begin
			s_d.bit_q = msb_first_in ? word_in[BITS-1] : word_in[0];
			s_d.sh    = msb_first_in ? {word_in[BITS-2:0], 1'b0} : {1'b0, word_in[BITS-1:1]};
		end else begin
			s_d.bit_q = msb_first_in ? s_q.sh[BITS-1] : s_q.sh[0];
			s_d.sh    = msb_first_in ? {s_q.sh[BITS-2:0], 1'b0} : {1'b0, s_q.sh[BITS-1:1]};
		end
		if (reset_in) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	assign bit_out = s_q.bit_q;
endmodule : oadc_lane_ser

// File: hdl/oadc_clk_mon.sv
// sample clock monitor: synchronises the clock pin and flags stop, slow and brief gaps
`timescale 1ns/10ps
`include "oadc_regs.svh"
module oadc_clk_mon #(
	parameter int STOP_CYC = `OADC_STOP_CYC,
	parameter int SLOW_CYC = 6
) (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic sample_clock_in,
	output logic      stopped_out,
	output logic      slow_out,
	output logic      brief_out
);
	import oadc_pkg::*;

	oadc_mon_st_t s_q;
	oadc_mon_st_t s_d;
	logic         edge_w;
	logic         rise_w;

	if (STOP_CYC < 1 || STOP_CYC > 254 || SLOW_CYC < 1 || SLOW_CYC > 254) begin : g_chk
		$error("oadc_clk_mon: thresholds must fit the 8-bit counters");
	end

	// edges are taken only from the second synchroniser stage
	assign edge_w = s_q.sync[1] ^ s_q.prev;
	assign rise_w = s_q.sync[1] & ~s_q.prev;

	// counters saturate so a long stop never wraps into a false healthy reading
	always_comb begin
		s_d       = s_q;
		s_d.sync  = {s_q.sync[0], sample_clock_in};
		s_d.prev  = s_q.sync[1];
		s_d.brief = 1'b0;
		if (edge_w) begin
			s_d.gap = '0;
			// a gap longer than half the last period that ended before the stop limit
			s_d.brief = !s_q.stopped && (s_q.last_period != '0) && (s_q.gap > {1'b0, s_q.last_period[7:1]});
		end else if (s_q.gap != `OADC_CNT_MAX) begin
			s_d.gap = s_q.gap + 8'h01;
		end
		if (rise_w) begin
			s_d.period      = '0;
			s_d.last_period = (s_q.period == `OADC_CNT_MAX) ? `OADC_CNT_MAX : s_q.period + 8'h01;
			s_d.slow        = s_q.period >= 8'(SLOW_CYC);
		end else if (s_q.period != `OADC_CNT_MAX) begin
			s_d.period = s_q.period + 8'h01;
		end
		s_d.stopped = s_d.gap > 8'(STOP_CYC);
		if (reset_in) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	assign stopped_out = s_q.stopped;
	assign slow_out    = s_q.slow;
	assign brief_out   = s_q.brief;
endmodule : oadc_clk_mon

// File: test/oadc_rx_model.sv
// receiver model: rebuilds each lane word against the frame clock
`timescale 1ns/10ps
module oadc_rx_model (
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	input  wire oadc_pkg::oadc_lanes_t lane_in,
	input  wire oadc_pkg::oadc_pair_t  bit_clk_in,
	input  wire oadc_pkg::oadc_pair_t  frame_clk_in,
	input  wire logic                  valid_in,
	output oadc_pkg::oadc_words_t      word_out,
	output logic                       word_stb_out,
	output logic                       word_ok_out
);
	import oadc_pkg::*;
	oadc_words_t acc;
	int          idx;
	logic        ok;
	logic        prev_f;

	// bits held in time order; a word is only trusted while the sender marks output valid
	always @(posedge clk_in) begin
		word_stb_out <= 1'b0;
		if (reset_in) begin
			idx = 12;
			ok = 1'b0;
		end else begin
			if (frame_clk_in.p && !prev_f) begin
				idx = 0;
				ok = bit_clk_in.p;
			end
			if (idx < 12) begin
				for (int c = 0; c < 8; c++)
					acc[c][idx] = lane_in[c].p;
				ok = ok & valid_in & lane_in[0].oe;
				if (idx == 11) begin
					word_out <= acc;
					word_ok_out <= ok;
					word_stb_out <= 1'b1;
				end
				idx++;
			end
		end
		prev_f = frame_clk_in.p;
	end
endmodule : oadc_rx_model

// File: test/oadc_serial_chk.sv
// assertion checker for the serial output and power control block
`timescale 1ns/10ps
`include "oadc_regs.svh"
module oadc_serial_chk (
	input wire logic                   clk_in,
	input wire logic                   reset_in,
	input wire logic                   sample_clock_in,
	input wire logic                   power_down_pin_in,
	input wire oadc_pkg::oadc_lanes_t  data_lane_out,
	input wire oadc_pkg::oadc_pair_t   bit_clock_pair_out,
	input wire oadc_pkg::oadc_pair_t   frame_clock_pair_out,
	input wire logic [1:0]             drive_sel_out,
	input wire logic [`OADC_CHANS-1:0] chan_enable_out,
	input wire logic                   ref_enable_out,
	input wire logic                   clock_circuit_enable_out,
	input wire logic                   partial_pd_out,
	input wire logic                   data_valid_out
);
	import oadc_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// frame shape and the stopped sample clock are built from steps
	sequence s_hi; frame_clock_pair_out.p [*6]; endsequence
	sequence s_lo; !frame_clock_pair_out.p [*6]; endsequence
	sequence s_low; (!sample_clock_in && !power_down_pin_in) [*8]; endsequence
	sequence s_stop; data_valid_out ##1 s_low ##1 s_low; endsequence
	property p_bit; bit_clock_pair_out.p != $past(bit_clock_pair_out.p); endproperty
	property p_frame; $rose(frame_clock_pair_out.p) |-> s_hi ##1 s_lo; endproperty
	property p_align; $rose(frame_clock_pair_out.p) |-> bit_clock_pair_out.p; endproperty
	property p_float; power_down_pin_in [*6] |-> !(data_lane_out[0].oe | data_lane_out[7].oe
		| bit_clock_pair_out.oe | frame_clock_pair_out.oe); endproperty
	property p_off; power_down_pin_in [*6] |-> chan_enable_out == 8'h00 && !ref_enable_out
		&& !clock_circuit_enable_out; endproperty
	property p_pdrec; $fell(power_down_pin_in) |-> !data_valid_out [*8]; endproperty
	property p_stop; s_stop |-> ##[0:4] partial_pd_out; endproperty
	property p_prec; $fell(partial_pd_out) |-> !data_valid_out [*8]; endproperty
	property p_rst; $fell(reset_in) |-> drive_sel_out == 2'h0 && !data_valid_out; endproperty

	a_bit: assert property (p_bit) else $error("bit clock stalled");
	a_frame: assert property (p_frame) else $error("frame clock shape");
	a_align: assert property (p_align) else $error("frame not on bit clock high");
	a_float: assert property (p_float) else $error("driver on in power-down");
	a_off: assert property (p_off) else $error("circuits on in power-down");
	a_pdrec: assert property (p_pdrec) else $error("early valid after pin");
	a_stop: assert property (p_stop) else $error("no partial power-down");
	a_prec: assert property (p_prec) else $error("early valid after partial");
	a_rst: assert property (p_rst) else $error("reset defaults");
endmodule : oadc_serial_chk

bind oadc_serial_ctrl oadc_serial_chk u_chk (.clk_in, .reset_in, .sample_clock_in, .power_down_pin_in,
	.data_lane_out, .bit_clock_pair_out, .frame_clock_pair_out, .drive_sel_out, .chan_enable_out,
	.ref_enable_out, .clock_circuit_enable_out, .partial_pd_out, .data_valid_out);

// File: test/tb.sv
// self-checking bench for the serial output and power control block
`timescale 1ns/10ps
`include "oadc_regs.svh"
module tb;
	import oadc_pkg::*;
	logic        clk_in, reset_in, axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in, axi_rready_in;
	logic        sample_clock_in, power_down_pin_in, sclk_run, axi_awready_out, axi_wready_out, axi_bvalid_out;
	logic        axi_arready_out, axi_rvalid_out, ref_enable_out, clock_circuit_enable_out, partial_pd_out;
	logic        data_valid_out, rx_stb, rx_ok, sclk_hold;
	logic [3:0]  axi_awaddr_in, axi_wstrb_in, axi_araddr_in;
	logic [31:0] axi_wdata_in, axi_rdata_out, rd;
	logic [1:0]  axi_bresp_out, axi_rresp_out, drive_sel_out, rsp;
	logic [7:0]  chan_enable_out;
	oadc_words_t adc_data_in, rx_word;
	oadc_lanes_t data_lane_out;
	oadc_pair_t  bit_clock_pair_out, frame_clock_pair_out;
	int          error_cnt, checks_done, n;

	// shortened recovery counts keep the run brief; 2 MHz floor clears the 2.5 MHz bench clock
	oadc_serial_ctrl #(.PD_RECOVERY_CYC(20), .PARTIAL_CYC(20), .RELOCK_CYC(10), .MIN_FREQ_KHZ(2000)) dut (
		.clk_in, .reset_in, .axi_awaddr_in, .axi_awvalid_in, .axi_awready_out, .axi_wdata_in, .axi_wstrb_in,
		.axi_wvalid_in, .axi_wready_out, .axi_bresp_out, .axi_bvalid_out, .axi_bready_in, .axi_araddr_in,
		.axi_arvalid_in, .axi_arready_out, .axi_rdata_out, .axi_rresp_out, .axi_rvalid_out, .axi_rready_in,
		.adc_data_in, .sample_clock_in, .power_down_pin_in, .data_lane_out, .bit_clock_pair_out,
		.frame_clock_pair_out, .drive_sel_out, .chan_enable_out, .ref_enable_out, .clock_circuit_enable_out,
		.partial_pd_out, .data_valid_out);
	oadc_rx_model rx (.clk_in, .reset_in, .lane_in(data_lane_out), .bit_clk_in(bit_clock_pair_out),
		.frame_clk_in(frame_clock_pair_out), .valid_in(data_valid_out), .word_out(rx_word),
		.word_stb_out(rx_stb), .word_ok_out(rx_ok));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// payload held until its own ready; bready stays up until bvalid is seen
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		@(posedge clk_in);
		axi_awaddr_in <= a;
		axi_wdata_in <= d;
		axi_awvalid_in <= 1'b1;
		axi_wvalid_in <= 1'b1;
		axi_bready_in <= 1'b1;
		for (int i = 0; i < 50 && !b; i++) begin
			@(negedge clk_in);
			aw = axi_awvalid_in & (axi_awready_out === 1'b1);
			w = axi_wvalid_in & (axi_wready_out === 1'b1);
			b = axi_bvalid_out === 1'b1;
			rsp = axi_bresp_out;
			@(posedge clk_in);
			if (aw) axi_awvalid_in <= 1'b0;
			if (w) axi_wvalid_in <= 1'b0;
			if (b) axi_bready_in <= 1'b0;
		end
		if (!b) error_cnt++;
	endtask : axi_write

	task automatic axi_read(input logic [3:0] a);
		logic ar, r;
		r = 1'b0;
		@(posedge clk_in);
		axi_araddr_in <= a;
		axi_arvalid_in <= 1'b1;
		axi_rready_in <= 1'b1;
		for (int i = 0; i < 50 && !r; i++) begin
			@(negedge clk_in);
			ar = axi_arvalid_in & (axi_arready_out === 1'b1);
			r = axi_rvalid_out === 1'b1;
			rd = axi_rdata_out;
			@(posedge clk_in);
			if (ar) axi_arvalid_in <= 1'b0;
			if (r) axi_rready_in <= 1'b0;
		end
		if (!r) error_cnt++;
	endtask : axi_read

	// the first words after a change may mix settings, so only the k-th is kept
	task automatic get_word(input int k);
		int t;
		repeat (k) begin
			t = 0;
			do begin
				@(negedge clk_in);
				t++;
			end while (!(rx_stb === 1'b1 && rx_ok === 1'b1) && t < 100);
			if (t >= 100) error_cnt++;
		end
	endtask : get_word

	task automatic wait_valid();
		n = 0;
		while (data_valid_out !== 1'b1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
	endtask : wait_valid

	function automatic oadc_word_t rev12(input oadc_word_t v);
		for (int i = 0; i < 12; i++)
			rev12[i] = v[11-i];
	endfunction : rev12

	task automatic t_reset();
		logic lp;
		int   tog;
		tog = 0;
		repeat (3) @(negedge clk_in);
		lp = bit_clock_pair_out.p;
		repeat (16) begin
			@(negedge clk_in);
			tog += int'(bit_clock_pair_out.p !== lp);
			lp = bit_clock_pair_out.p;
		end
		chk(tog, 32'h10);
		chk({data_lane_out[0].p, data_lane_out[0].oe, bit_clock_pair_out.oe}, 32'h3);
		@(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			axi_read(4'(i * 4));
			chk(rd, `OADC_CFG_RESET);
		end
		chk(drive_sel_out, 32'h0);
	endtask : t_reset

	task automatic t_data();
		wait_valid();
		axi_read(`OADC_ADDR_STAT);
		chk(rd, 32'h8);
		axi_write(`OADC_ADDR_STAT, 32'hF);
		chk(rsp, `OADC_RESP_SLVERR);
		get_word(3);
		for (int c = 0; c < 8; c++)
			chk(rx_word[c], adc_data_in[c]);
		axi_write(`OADC_ADDR_CTRL, 32'h1);
		get_word(3);
		for (int c = 0; c < 8; c++)
			chk(rx_word[c], rev12(adc_data_in[c]));
		axi_write(`OADC_ADDR_CTRL, 32'h0);
		axi_write(`OADC_ADDR_CHPD, 32'h8);
		get_word(3);
		chk({rx_word[3], rx_word[2], chan_enable_out}, {12'h0, adc_data_in[2], 8'hF7});
	endtask : t_data

	task automatic t_patt();
		logic [31:0] ctl [5] = '{32'h2, 32'h4, 32'h8, 32'h6, 32'h9};
		logic [11:0] exp [5] = '{12'hAAA, 12'hFC0, 12'h3A5, 12'hAAA, 12'hA5C};
		axi_write(`OADC_ADDR_PATT, 32'h3A5);
		for (int i = 0; i < 5; i++) begin
			axi_write(`OADC_ADDR_CTRL, ctl[i]);
			get_word(3);
			for (int c = 0; c < 8; c++)
				chk(rx_word[c], exp[i]);
		end
		for (int d = 0; d < 4; d++) begin
			axi_write(`OADC_ADDR_CTRL, 32'(d << 4));
			chk(drive_sel_out, d);
		end
		axi_write(`OADC_ADDR_CHPD, 32'h0);
	endtask : t_patt

	task automatic t_power();
		@(posedge clk_in);
		power_down_pin_in <= 1'b1;
		repeat (8) @(negedge clk_in);
		chk({data_lane_out[0].oe, data_lane_out[7].oe, bit_clock_pair_out.oe, frame_clock_pair_out.oe}, 0);
		chk({chan_enable_out, ref_enable_out, clock_circuit_enable_out}, 0);
		@(posedge clk_in);
		power_down_pin_in <= 1'b0;
		wait_valid();
		chk(n >= 20 && n <= 30, 32'h1);
		@(posedge clk_in);
		sclk_run <= 1'b0;
		repeat (30) @(negedge clk_in);
		chk({partial_pd_out, data_valid_out}, 32'h2);
		@(posedge clk_in);
		sclk_run <= 1'b1;
		wait_valid();
		chk(n >= 20 && n <= 80, 32'h1);
	endtask : t_power

	// a one-off stretched half period is a brief gap: valid drops, relocks, then returns
	task automatic t_relock();
		@(posedge clk_in);
		sclk_hold <= ~sclk_hold;
		n = 0;
		while (data_valid_out === 1'b1 && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		chk({partial_pd_out, data_valid_out, n > 0 && n < 40}, 32'h1);
		wait_valid();
		chk(n >= 10 && n <= 12, 32'h1);
	endtask : t_relock

	// sample clock is unrelated in phase and parks low while stopped
	initial begin : sclk_gen
		logic hold_seen;
		hold_seen = 1'b0;
		sample_clock_in = 1'b0;
		#13;
		forever begin
			#200;
			// each toggle of sclk_hold stretches one half period to 300 ns, the stop limit, without being flagged as stopped
			if (sclk_hold !== hold_seen) begin
				hold_seen = sclk_hold;
				#100;
			end
			sample_clock_in = sclk_run ? ~sample_clock_in : 1'b0;
		end
	end

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	initial begin
		#500000;
		error_cnt++;
		conclude();
	end

	initial begin
		{reset_in, sclk_run, axi_wstrb_in} = 6'h3F;
		{axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in, axi_rready_in} = 5'h0;
		{axi_awaddr_in, axi_araddr_in, axi_wdata_in, power_down_pin_in} = '0;
		error_cnt = 0;
		checks_done = 0;
		sclk_hold = 1'b0;
		for (int c = 0; c < 8; c++)
			adc_data_in[c] = 12'(12'h6C3 ^ (12'h111 * c));
		t_reset();
		t_data();
		t_patt();
		t_power();
		t_relock();
		conclude();
	end
endmodule : tb
